// file: rtl/ilo_addr_gen.sv
`timescale 1ns/1ps
// Behaviour
// - extended set, forced access, field <= 5Fh: address = pointer two + field.
// - access bit one: bank register plus field, extended set or not.
// - forced access with field 60h or above maps into F60h..FFFh.
// - indexed window spans pointer two through pointer two plus 95.
// - virtual indirect operands keep plain indirect addressing, no offset remap.
// - pointers zero/one, inherent/literal, register map unchanged by extended set.
// - extended set adds five two-word instructions to the decoder.
// - access bit, destination bit and 8-bit file field follow add-w-to-file layout.
// - outside indexed mode, access bit selects banked or access-bank address.
// - each pointer pair holds a 12-bit linear address.
module ilo_addr_gen
    import ilo_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic extended_set_enable_i,
    input wire ilo_req_s req_i,
    input wire ilo_ptr_s ptr_i,
    output ilo_rsp_s rsp_o
);


    // ----------------------------------------------------------------
    // operand fields and helper nets
    // ----------------------------------------------------------------
    logic acc_bit;
    logic dst_bit;
    logic [FILE_W-1:0] file_f;
    logic is_indirect;
    logic is_file;
    logic is_offset;
    logic [ADDR_W-1:0] idx_sum;
    logic [ADDR_W-1:0] win_top;

    // ----------------------------------------------------------------
    // registered response, one group per kind of result
    // ----------------------------------------------------------------
    logic valid_r;
    logic valid_nxt;
    ilo_mode_e mode_r;
    ilo_mode_e mode_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic dest_r;
    logic dest_nxt;
    logic [ADDR_W-1:0] win_lo_r;
    logic [ADDR_W-1:0] win_lo_nxt;
    logic [ADDR_W-1:0] win_hi_r;
    logic [ADDR_W-1:0] win_hi_nxt;
    ilo_xop_e xop_r;
    ilo_xop_e xop_nxt;

    // ----------------------------------------------------------------
    // field extraction
    // ----------------------------------------------------------------
    // add-w-to-file layout
    assign acc_bit = req_i.opcode[OPC_A_BIT];
    assign dst_bit = req_i.opcode[OPC_D_BIT];
    assign file_f = req_i.opcode[OPC_F_LSB +: FILE_W];

    // ----------------------------------------------------------------
    // operand classification
    // ----------------------------------------------------------------
    // indirect operand overrides file field
    assign is_indirect = req_i.valid && req_i.indirect;
    assign is_file = req_i.valid && req_i.file_op && !req_i.indirect;
    assign is_offset = extended_set_enable_i && !acc_bit && (file_f <= IDX_MAX);

    // ----------------------------------------------------------------
    // pointer arithmetic
    // ----------------------------------------------------------------
    // twelve-bit pointer sum
    // carry out of the top bit is dropped so the window wraps round data memory
    assign idx_sum = ADDR_W'(ptr_i.ptr_two + {{(ADDR_W-FILE_W){1'b0}}, file_f});
    assign win_top = ADDR_W'(ptr_i.ptr_two + WIN_SPAN);
    // pointers zero and one reach this block only through the chosen indirect address

    // ----------------------------------------------------------------
    // address group
    // ----------------------------------------------------------------
    always_comb
    begin
        valid_nxt = req_i.valid;
        mode_nxt = ILO_MODE_NONE;
        addr_nxt = ADDR_RST;
        dest_nxt = 1'b0;
        if (is_indirect)
        begin
            mode_nxt = ILO_MODE_INDIRECT;
            addr_nxt = req_i.ind_addr;
        end
        else if (is_file)
        begin
            dest_nxt = dst_bit;
            if (acc_bit)
            begin
                mode_nxt = ILO_MODE_BANKED;
                addr_nxt = {ptr_i.bank_sel, file_f};
            end
            else if (is_offset)
            begin
                mode_nxt = ILO_MODE_INDEXED;
                addr_nxt = idx_sum;
            end
            else if (file_f > IDX_MAX)
            begin
                mode_nxt = ILO_MODE_FORCED;
                addr_nxt = {TOP_BANK, file_f};
            end
            else
            begin
                mode_nxt = ILO_MODE_FORCED;
                addr_nxt = {LOW_BANK, file_f};
            end
        end
        else
        begin
            // inherent and literal instructions leave the address at rest
            mode_nxt = ILO_MODE_NONE;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            valid_r <= 1'b0;
            mode_r <= ILO_MODE_NONE;
            addr_r <= ADDR_RST;
            dest_r <= 1'b0;
        end
        else
        begin
            valid_r <= valid_nxt;
            mode_r <= mode_nxt;
            addr_r <= addr_nxt;
            dest_r <= dest_nxt;
        end
    end

    // ----------------------------------------------------------------
    // indexed window bounds
    // ----------------------------------------------------------------
    // bounds follow pointer two
    // they track every cycle, so they stay meaningful between requests
    always_comb
    begin
        win_lo_nxt = ptr_i.ptr_two;
        win_hi_nxt = win_top;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            win_lo_r <= ADDR_RST;
            win_hi_r <= ADDR_RST;
        end
        else
        begin
            win_lo_r <= win_lo_nxt;
            win_hi_r <= win_hi_nxt;
        end
    end

    // ----------------------------------------------------------------
    // extended instruction decode
    // ----------------------------------------------------------------
    // five two-word instructions
    // only the first word is decoded here; the core fetches the second one
    always_comb
    begin
        xop_nxt = ILO_X_NONE;
        if (req_i.valid && extended_set_enable_i)
        begin
            // first-word patterns are disjoint, so the order of the tests is free
            if (req_i.opcode == XOP_ICALL)
            begin
                xop_nxt = ILO_X_ICALL;
            end
            else if (req_i.opcode[OPC_W-1:XOP_BYTE_LSB] == XOP_PTR_ADD)
            begin
                xop_nxt = ILO_X_PTR_ADD;
            end
            else if (req_i.opcode[OPC_W-1:XOP_BYTE_LSB] == XOP_PTR_SUB)
            begin
                xop_nxt = ILO_X_PTR_SUB;
            end
            else if (req_i.opcode[OPC_W-1:XOP_NINE_LSB] == XOP_IDX_ABS)
            begin
                xop_nxt = ILO_X_IDX_ABS;
            end
            else if (req_i.opcode[OPC_W-1:XOP_NINE_LSB] == XOP_IDX_IDX)
            begin
                xop_nxt = ILO_X_IDX_IDX;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            xop_r <= ILO_X_NONE;
        end
        else
        begin
            xop_r <= xop_nxt;
        end
    end

    // ----------------------------------------------------------------
    // response
    // ----------------------------------------------------------------
    // every field comes straight from its own flip-flop
    assign rsp_o = '{
        valid: valid_r,
        mode: mode_r,
        addr: addr_r,
        dest_file: dest_r,
        xop: xop_r,
        win_lo: win_lo_r,
        win_hi: win_hi_r
    };

endmodule

// file: rtl/ilo_pkg.sv
package ilo_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned FILE_W = 8;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned OPC_W = 16;

    // ----------------------------------------------------------------
    // address map constants
    // ----------------------------------------------------------------
    // highest file field that is taken as an offset
    localparam logic [FILE_W-1:0] IDX_MAX = 8'h5f;
    // window span above the pointer
    localparam logic [ADDR_W-1:0] WIN_SPAN = 12'h05f;
    // forced accesses at 60h and above land in the top bank
    localparam logic [BANK_W-1:0] TOP_BANK = 4'hf;
    localparam logic [BANK_W-1:0] LOW_BANK = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

    // ----------------------------------------------------------------
    // opcode layout of byte-oriented instructions (add w to file)
    // ----------------------------------------------------------------
    localparam int unsigned OPC_A_BIT = 8;
    localparam int unsigned OPC_D_BIT = 9;
    localparam int unsigned OPC_F_LSB = 0;

    // extended two-word instruction first-word prefixes
    localparam logic [7:0] XOP_PTR_ADD = 8'he8;
    localparam logic [7:0] XOP_PTR_SUB = 8'he9;
    localparam logic [15:0] XOP_ICALL = 16'h0014;
    localparam logic [8:0] XOP_IDX_ABS = 9'h1d6;
    localparam logic [8:0] XOP_IDX_IDX = 9'h1d7;
    // lowest opcode bit of the eight-bit and nine-bit prefixes
    localparam int unsigned XOP_BYTE_LSB = 8;
    localparam int unsigned XOP_NINE_LSB = 7;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ILO_MODE_NONE,
        ILO_MODE_BANKED,
        ILO_MODE_FORCED,
        ILO_MODE_INDEXED,
        ILO_MODE_INDIRECT
    } ilo_mode_e;

    typedef enum logic [2:0] {
        ILO_X_NONE,
        ILO_X_PTR_ADD,
        ILO_X_ICALL,
        ILO_X_IDX_ABS,
        ILO_X_IDX_IDX,
        ILO_X_PTR_SUB
    } ilo_xop_e;

    // one decode request from the instruction decoder
    typedef struct packed {
        logic valid;
        logic file_op;
        logic indirect;
        logic [ADDR_W-1:0] ind_addr;
        logic [OPC_W-1:0] opcode;
    } ilo_req_s;

    // pointer and bank state of the core
    typedef struct packed {
        logic [BANK_W-1:0] bank_sel;
        logic [ADDR_W-1:0] ptr_zero;
        logic [ADDR_W-1:0] ptr_one;
        logic [ADDR_W-1:0] ptr_two;
    } ilo_ptr_s;

    // generated operand address
    typedef struct packed {
        logic valid;
        ilo_mode_e mode;
        logic [ADDR_W-1:0] addr;
        logic dest_file;
        ilo_xop_e xop;
        logic [ADDR_W-1:0] win_lo;
        logic [ADDR_W-1:0] win_hi;
    } ilo_rsp_s;

endpackage

// file: bench/ilo_chk.sv
`timescale 1ns/1ps
module ilo_chk
    import ilo_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic extended_set_enable_i,
    input wire ilo_req_s req_i,
    input wire ilo_ptr_s ptr_i,
    input wire ilo_rsp_s rsp_o
);
    wire logic [7:0] f = req_i.opcode[7:0];
    wire logic fo = req_i.valid && req_i.file_op && !req_i.indirect;
    wire logic a = req_i.opcode[8];
    wire logic x = extended_set_enable_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    index_addr_a: assert property (fo && !a && x && f <= 8'h5f |=>
        rsp_o.mode == ILO_MODE_INDEXED && rsp_o.addr == $past(ptr_i.ptr_two) + $past(f)) else $error("bad index");
    bank_addr_a: assert property (fo && a |=> rsp_o.addr == {$past(ptr_i.bank_sel), $past(f)})
        else $error("bad bank");
    top_bank_a: assert property (fo && !a && f > 8'h5f |=> rsp_o.addr == {4'hf, $past(f)})
        else $error("bad top");
    win_span_a: assert property (req_i.valid |=> rsp_o.win_lo == $past(ptr_i.ptr_two) &&
        rsp_o.win_hi == rsp_o.win_lo + 12'h05f) else $error("bad window");
    ind_keep_a: assert property (req_i.valid && req_i.indirect |=>
        rsp_o.mode == ILO_MODE_INDIRECT && rsp_o.addr == $past(req_i.ind_addr)) else $error("bad indirect");
    dest_bit_a: assert property (fo |=> rsp_o.dest_file == $past(req_i.opcode[9]))
        else $error("bad dest");
    low_bank_a: assert property (fo && !a && !x && f <= 8'h5f |=> rsp_o.addr == {4'h0, $past(f)})
        else $error("bad access");
    xop_off_a: assert property (req_i.valid && !x |=> rsp_o.xop == ILO_X_NONE)
        else $error("bad xop");
    icall_dec_a: assert property (req_i.valid && x && req_i.opcode == 16'h0014 |=> rsp_o.xop == ILO_X_ICALL)
        else $error("bad call decode");
endmodule
bind ilo_addr_gen ilo_chk chk (.mclk_i, .rst_b_i, .extended_set_enable_i, .req_i, .ptr_i, .rsp_o);

// file: bench/ilo_addr_gen_tb.sv
`timescale 1ns/1ps
module ilo_addr_gen_tb
    import ilo_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic xen = 1'b0;
    ilo_req_s req = '0;
    ilo_ptr_s ptr = '0;
    ilo_rsp_s rsp;
    ilo_rsp_s e;
    logic [31:0] lf = 32'h0001379e;
    logic [15:0] ctab [9] = '{16'h2405, 16'h245f, 16'h2460, 16'h25ff, 16'he8c1, 16'he9c1, 16'h0014, 16'heb00, 16'heb80};
    int n_mismatch = 0;
    int n_compared = 0;
    always #50 mclk_i = ~mclk_i;
    ilo_addr_gen dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .extended_set_enable_i(xen), .req_i(req), .ptr_i(ptr),
        .rsp_o(rsp));
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic ilo_rsp_s want(logic x, ilo_req_s r, ilo_ptr_s p);
        ilo_rsp_s o;
        logic [7:0] f;
        logic low;
        f = r.opcode[7:0];
        low = f < 8'h60;
        o = '0;
        o.valid = r.valid;
        // window bounds follow pointer two even between requests
        o.win_lo = p.ptr_two;
        o.win_hi = p.ptr_two + 12'h05f;
        if (r.valid && r.indirect)
        begin
            o.mode = ILO_MODE_INDIRECT;
            o.addr = r.ind_addr;
        end
        else if (r.valid && r.file_op)
        begin
            o.dest_file = r.opcode[9];
            o.mode = r.opcode[8] ? ILO_MODE_BANKED : x && low ? ILO_MODE_INDEXED : ILO_MODE_FORCED;
            // pointer plus offset wraps at 12 bits
            o.addr = r.opcode[8] ? {p.bank_sel, f} : x && low ? p.ptr_two + f : {low ? 4'h0 : 4'hf, f};
        end
        if (r.valid && x)
            o.xop = r.opcode[15:8] == 8'he8 ? ILO_X_PTR_ADD : r.opcode[15:8] == 8'he9 ? ILO_X_PTR_SUB :
                r.opcode == 16'h0014 ? ILO_X_ICALL : r.opcode[15:7] == 9'h1d6 ? ILO_X_IDX_ABS :
                r.opcode[15:7] == 9'h1d7 ? ILO_X_IDX_IDX : ILO_X_NONE;
        return o;
    endfunction
    task automatic check(logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_mismatch++;
        conclude();
    end
    initial
    begin
        repeat (20) @(posedge mclk_i);
        #1 rst_b_i = 1'b1;
        // the first answer after release reflects the idle request held through reset
        e = want(xen, req, ptr);
        for (int i = 0; i < 2000; i++)
        begin
            @(posedge mclk_i);
            #1;
            check(rsp.valid, e.valid);
            check(rsp.mode, e.mode);
            check(rsp.addr, e.addr);
            check(rsp.dest_file, e.dest_file);
            check(rsp.xop, e.xop);
            check(rsp.win_lo, e.win_lo);
            check(rsp.win_hi, e.win_hi);
            lf = lfsr_next(lf);
            // first cases walk the opcode table against a pointer near the top
            req.valid = i < 40 || lf[0];
            req.file_op = i < 40 || lf[1];
            req.indirect = i >= 40 && lf[2] && lf[3];
            req.ind_addr = lf[27:16];
            req.opcode = i < 40 ? ctab[i % 9] : lf[31:16];
            xen = i < 18 ? i >= 9 : lf[4];
            ptr = {lf[3:0], lf[31:20], lf[19:8], i < 40 ? 12'hfe0 : lf[11:0]};
            e = want(xen, req, ptr);
        end
        conclude();
    end
endmodule
